// [include/pulse_timer_ch0_pkg.sv]
// Purpose: Shared constants for the channel 0 mode control block.
// Assumes: 32-bit classic Wishbone, byte addresses, low byte lane used.
// Notes:   Only the low eight bits of each register word are live.
package pulse_timer_ch0_pkg;

   // Register byte offsets
   localparam logic [7:0] ADR_MODE_CTRL  = 8'h00;
   localparam logic [7:0] ADR_EVT_STATUS = 8'h04;
   localparam logic [7:0] ADR_EVT_CLEAR  = 8'h08;
   localparam logic [7:0] ADR_EVT_ENABLE = 8'h0c;

   // Field positions in the mode control register
   localparam int BIT_RESERVED  = 0;
   localparam int BIT_UNUSED_1  = 1;
   localparam int BIT_UNUSED_2  = 2;
   localparam int BIT_UF_FLAG   = 3;
   localparam int BIT_UF_IRQ_EN = 4;
   localparam int BIT_PIN_EN    = 5;
   localparam int BIT_UNUSED_6  = 6;
   localparam int BIT_COUNT_EN  = 7;

   // Field positions in the event status, clear and enable registers
   localparam int EVT_UNDERFLOW  = 0;
   localparam int EVT_BAD_MODE   = 1;
   localparam int EVT_WIDTH      = 2;

   // Values after reset
   localparam logic [7:0] RST_MODE_CTRL = 8'h00;
   localparam logic [1:0] RST_EVT       = 2'h0;
   localparam logic [31:0] RST_RDATA    = 32'h0000_0000;

   // Operating mode codes from the companion channel 1 register
   localparam logic [1:0] MODE_8BIT_INDEP = 2'h0;
   localparam logic [1:0] MODE_8PLUS8     = 2'h1;
   localparam logic [1:0] MODE_FORBIDDEN  = 2'h2;
   localparam logic [1:0] MODE_16BIT      = 2'h3;

   // Counter terminal values before an underflow
   localparam logic [7:0]  CNT8_ZERO  = 8'h00;
   localparam logic [15:0] CNT16_ZERO = 16'h0000;

endpackage

// [rtl/pulse_timer_ch0_mode_control.sv]
// Purpose: Mode control register of pulse channel 0 with Wishbone slave,
//          underflow flag, pin function select and event interrupts.
// Assumes: Counter datapath outside supplies the count tick and the
//          counter values; all inputs are synchronous to clk_i.
// Notes:   One clock, ce_i low freezes every flip-flop.
// Behaviour
// - Unused bits one two six: ignore writes
// - 8-bit modes: flag on 00 to FF
// - 16-bit mode: flag on 0000 to FFFF
// - Flag and enable raise interrupt request
// - Writing zero clears flag, one no effect
// - Read-modify-write reads flag as one
// - Bit five selects pulse output on pin
// - Counting allowed only while bit seven set
// - Disabled counting holds pulse output low
// - 16-bit mode joins both 8-bit counters
`timescale 1ns/1ps
module pulse_timer_ch0_mode_control (
   input  wire logic        clk_i,              // Machine clock, 20 MHz
   input  wire logic        rst_i,              // Sync reset, active high
   input  wire logic        ce_i,               // Clock enable, freezes all
   input  wire logic        wb_cyc_i,           // Wishbone cycle
   input  wire logic        wb_stb_i,           // Wishbone strobe
   input  wire logic        wb_we_i,            // Wishbone write enable
   input  wire logic [7:0]  wb_adr_i,           // Wishbone byte address
   input  wire logic [3:0]  wb_sel_i,           // Wishbone byte selects
   input  wire logic [31:0] wb_dat_i,           // Wishbone write data
   output logic      [31:0] wb_dat_o,           // Wishbone read data
   output logic             wb_ack_o,           // Wishbone acknowledge
   input  wire logic        rmw_i,              // Read is part of RMW
   input  wire logic        count_tick_i,       // Counter decrement strobe
   input  wire logic [7:0]  counter0_value_i,   // Channel 0 counter value
   input  wire logic [7:0]  counter1_value_i,   // Channel 1 counter value
   input  wire logic        mode_select_high_i, // Companion mode bit high
   input  wire logic        mode_select_low_i,  // Companion mode bit low
   input  wire logic        pulse_level_i,      // Pulse generator level
   input  wire logic        port_data_i,        // Port output data latch
   input  wire logic        port_dir_i,         // Port direction, 1 = out
   output logic             count_run_o,        // Counter may decrement
   output logic             pulse_pin_select_o, // Pin carries pulse
   output logic             pin_o,              // Pin output level
   output logic             pin_oe_n_o,         // Pin drive, low = driven
   output logic             underflow_irq_o,    // Underflow interrupt req
   output logic             irq_o               // Event interrupt, level
);

   // Control register fields
   logic       reserved_bit;
   logic       underflow_flag;
   logic       underflow_irq_enable;
   logic       pulse_pin_enable;
   logic       count_enable;
   logic       next_reserved_bit;
   logic       next_underflow_flag;
   logic       next_underflow_irq_enable;
   logic       next_pulse_pin_enable;
   logic       next_count_enable;

   // Event status and enable
   logic [1:0] evt_status;
   logic [1:0] evt_enable;
   logic       bad_mode_seen;
   logic [1:0] next_evt_status;
   logic [1:0] next_evt_enable;
   logic       next_bad_mode_seen;

   // Bus answer
   logic        wb_ack;
   logic [31:0] wb_rdata;
   logic        next_wb_ack;
   logic [31:0] next_wb_rdata;

   // Registered outputs
   logic count_run;
   logic pin_select;
   logic pin_level;
   logic pin_oe_n;
   logic uf_irq;
   logic evt_irq;
   logic next_count_run;
   logic next_pin_select;
   logic next_pin_level;
   logic next_pin_oe_n;
   logic next_uf_irq;
   logic next_evt_irq;

   // Decoded bus request and events
   logic       bus_req;
   logic       wr_low_lane;
   logic       wr_mode;
   logic       wr_clear;
   logic       wr_enable;
   logic       underflow_evt;
   logic       bad_mode_now;
   logic [1:0] mode_sel;

   // Address compare, used for every register
   function automatic logic adr_hit(input logic [7:0] adr,
                                    input logic [7:0] offset);
      adr_hit = (adr[7:2] == offset[7:2]);
   endfunction

   // Underflow on this tick: counter about to wrap below zero
   function automatic logic wraps(input logic [1:0] mode,
                                  input logic [7:0] c0,
                                  input logic [7:0] c1);
      if (mode == pulse_timer_ch0_pkg::MODE_16BIT) begin
         wraps = ({c1, c0} == pulse_timer_ch0_pkg::CNT16_ZERO);
      end else begin
         wraps = (c0 == pulse_timer_ch0_pkg::CNT8_ZERO);
      end
   endfunction

   assign mode_sel = {mode_select_high_i, mode_select_low_i};

   // Write takes effect on the cycle the request is first seen; ack
   // follows one cycle later while the master still holds the request
   assign bus_req     = wb_cyc_i & wb_stb_i & ~wb_ack;
   assign wr_low_lane = bus_req & wb_we_i & wb_sel_i[0];
   assign wr_mode     = wr_low_lane &
                        adr_hit(wb_adr_i, pulse_timer_ch0_pkg::ADR_MODE_CTRL);
   assign wr_clear    = wr_low_lane &
                        adr_hit(wb_adr_i, pulse_timer_ch0_pkg::ADR_EVT_CLEAR);
   assign wr_enable   = wr_low_lane &
                        adr_hit(wb_adr_i, pulse_timer_ch0_pkg::ADR_EVT_ENABLE);

   // Ticks while disabled are not counts, so they cannot underflow
   assign underflow_evt = count_tick_i & count_enable &
                          wraps(mode_sel, counter0_value_i,
                                counter1_value_i);

   // Pattern 10 is not a mode; it is only reported, counting stays 8-bit
   assign bad_mode_now = (mode_sel == pulse_timer_ch0_pkg::MODE_FORBIDDEN);

   // Control register next values
   always_comb begin
      next_reserved_bit         = reserved_bit;
      next_underflow_irq_enable = underflow_irq_enable;
      next_pulse_pin_enable     = pulse_pin_enable;
      next_count_enable         = count_enable;
      next_underflow_flag       = underflow_flag;
      if (wr_mode) begin
         // Bits one, two and six have no storage at all
         next_reserved_bit = wb_dat_i[pulse_timer_ch0_pkg::BIT_RESERVED];
         next_underflow_irq_enable =
            wb_dat_i[pulse_timer_ch0_pkg::BIT_UF_IRQ_EN];
         next_pulse_pin_enable = wb_dat_i[pulse_timer_ch0_pkg::BIT_PIN_EN];
         next_count_enable     = wb_dat_i[pulse_timer_ch0_pkg::BIT_COUNT_EN];
         if (!wb_dat_i[pulse_timer_ch0_pkg::BIT_UF_FLAG]) begin
            next_underflow_flag = 1'b0;
         end
      end
      if (underflow_evt) begin
         next_underflow_flag = 1'b1;
      end
   end

   // Event status next values, a set beats a clear in the same cycle
   always_comb begin
      next_evt_status    = evt_status;
      next_evt_enable    = evt_enable;
      next_bad_mode_seen = bad_mode_now;
      if (wr_clear) begin
         next_evt_status = evt_status & ~wb_dat_i[1:0];
      end
      if (wr_enable) begin
         next_evt_enable = wb_dat_i[1:0];
      end
      if (underflow_evt) begin
         next_evt_status[pulse_timer_ch0_pkg::EVT_UNDERFLOW] = 1'b1;
      end
      if (bad_mode_now && !bad_mode_seen) begin
         next_evt_status[pulse_timer_ch0_pkg::EVT_BAD_MODE] = 1'b1;
      end
   end

   // Bus answer next values; unmapped addresses read zero and ack
   always_comb begin
      next_wb_ack   = bus_req;
      next_wb_rdata = pulse_timer_ch0_pkg::RST_RDATA;
      if (bus_req && !wb_we_i) begin
         if (adr_hit(wb_adr_i, pulse_timer_ch0_pkg::ADR_MODE_CTRL)) begin
            // Unused bits read as zero, which is one legal undefined value
            next_wb_rdata[pulse_timer_ch0_pkg::BIT_RESERVED] =
               reserved_bit;
            next_wb_rdata[pulse_timer_ch0_pkg::BIT_UF_FLAG] =
               underflow_flag | rmw_i;
            next_wb_rdata[pulse_timer_ch0_pkg::BIT_UF_IRQ_EN] =
               underflow_irq_enable;
            next_wb_rdata[pulse_timer_ch0_pkg::BIT_PIN_EN] =
               pulse_pin_enable;
            next_wb_rdata[pulse_timer_ch0_pkg::BIT_COUNT_EN] =
               count_enable;
         end else if (adr_hit(wb_adr_i,
                              pulse_timer_ch0_pkg::ADR_EVT_STATUS)) begin
            next_wb_rdata[1:0] = evt_status;
         end else if (adr_hit(wb_adr_i,
                              pulse_timer_ch0_pkg::ADR_EVT_ENABLE)) begin
            next_wb_rdata[1:0] = evt_enable;
         end else begin
            next_wb_rdata = pulse_timer_ch0_pkg::RST_RDATA;
         end
      end
   end

   // Output next values, computed from next state so that the outputs
   // move in the same cycle as the register bits behind them
   always_comb begin
      next_count_run  = next_count_enable;
      next_pin_select = next_pulse_pin_enable;
      next_uf_irq     = next_underflow_flag & next_underflow_irq_enable;
      next_evt_irq    = |(next_evt_status & next_evt_enable);
      if (next_pulse_pin_enable) begin
         // Pulse forced low while stopped, whatever the generator shows
         next_pin_level = pulse_level_i & next_count_enable;
         next_pin_oe_n  = 1'b0;
      end else begin
         next_pin_level = port_data_i;
         next_pin_oe_n  = ~port_dir_i;
      end
   end

   // Control register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reserved_bit         <= pulse_timer_ch0_pkg::RST_MODE_CTRL[0];
         underflow_flag       <= pulse_timer_ch0_pkg::RST_MODE_CTRL[3];
         underflow_irq_enable <= pulse_timer_ch0_pkg::RST_MODE_CTRL[4];
         pulse_pin_enable     <= pulse_timer_ch0_pkg::RST_MODE_CTRL[5];
         count_enable         <= pulse_timer_ch0_pkg::RST_MODE_CTRL[7];
      end else if (ce_i) begin
         reserved_bit         <= next_reserved_bit;
         underflow_flag       <= next_underflow_flag;
         underflow_irq_enable <= next_underflow_irq_enable;
         pulse_pin_enable     <= next_pulse_pin_enable;
         count_enable         <= next_count_enable;
      end
   end

   // Event status and enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         evt_status    <= pulse_timer_ch0_pkg::RST_EVT;
         evt_enable    <= pulse_timer_ch0_pkg::RST_EVT;
         bad_mode_seen <= 1'b0;
      end else if (ce_i) begin
         evt_status    <= next_evt_status;
         evt_enable    <= next_evt_enable;
         bad_mode_seen <= next_bad_mode_seen;
      end
   end

   // Bus answer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack   <= 1'b0;
         wb_rdata <= pulse_timer_ch0_pkg::RST_RDATA;
      end else if (ce_i) begin
         wb_ack   <= next_wb_ack;
         wb_rdata <= next_wb_rdata;
      end
   end

   // Registered outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_run  <= 1'b0;
         pin_select <= 1'b0;
         pin_level  <= 1'b0;
         pin_oe_n   <= 1'b1;
         uf_irq     <= 1'b0;
         evt_irq    <= 1'b0;
      end else if (ce_i) begin
         count_run  <= next_count_run;
         pin_select <= next_pin_select;
         pin_level  <= next_pin_level;
         pin_oe_n   <= next_pin_oe_n;
         uf_irq     <= next_uf_irq;
         evt_irq    <= next_evt_irq;
      end
   end

   assign wb_ack_o           = wb_ack;
   assign wb_dat_o           = wb_rdata;
   assign count_run_o        = count_run;
   assign pulse_pin_select_o = pin_select;
   assign pin_o              = pin_level;
   assign pin_oe_n_o         = pin_oe_n;
   assign underflow_irq_o    = uf_irq;
   assign irq_o              = evt_irq;

endmodule

// [test/pulse_timer_ch0_mode_control_checker.sv]
// Purpose: Port relations of the channel 0 mode control block.
// Assumes: Only top ports seen; a shadow copy of the written byte tracks bits 7 and 4.
// Notes:   Frozen cycles (ce_i low) are skipped rather than modelled.
`timescale 1ns/1ps
module pulse_timer_ch0_mode_control_checker (
   input wire logic        clk_i,              // clock
   input wire logic        rst_i,              // reset
   input wire logic        ce_i,               // enable
   input wire logic        wb_cyc_i,           // cycle
   input wire logic        wb_stb_i,           // strobe
   input wire logic        wb_we_i,            // write
   input wire logic [7:0]  wb_adr_i,           // address
   input wire logic [3:0]  wb_sel_i,           // selects
   input wire logic [31:0] wb_dat_i,           // wdata
   input wire logic [31:0] wb_dat_o,           // rdata
   input wire logic        wb_ack_o,           // ack
   input wire logic        rmw_i,              // rmw
   input wire logic        count_tick_i,       // tick
   input wire logic [7:0]  counter0_value_i,   // cnt0
   input wire logic [7:0]  counter1_value_i,   // cnt1
   input wire logic        mode_select_high_i, // mode hi
   input wire logic        mode_select_low_i,  // mode lo
   input wire logic        port_data_i,        // port
   input wire logic        count_run_o,        // run
   input wire logic        pulse_pin_select_o, // select
   input wire logic        pin_o,              // pin
   input wire logic        pin_oe_n_o,         // drive
   input wire logic        underflow_irq_o     // irq
);
   logic [7:0] shadow;
   logic [7:0] next_shadow;
   logic       taken;
   logic       wr_ctrl;
   logic       uf_ev;
   logic       next_en;
   assign taken = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_ctrl = taken & wb_we_i & wb_sel_i[0] & (wb_adr_i == 8'h00);
   assign uf_ev = count_tick_i & count_run_o &
      (({mode_select_high_i, mode_select_low_i} == 2'h3) ?
       ({counter1_value_i, counter0_value_i} == 16'h0000) :
       (counter0_value_i == 8'h00));
   // Write in the same edge as an underflow decides the enable
   assign next_en = wr_ctrl ? wb_dat_i[4] : shadow[4];
   always_comb begin
      next_shadow = shadow;
      if (wr_ctrl) begin
         next_shadow = wb_dat_i[7:0];
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shadow <= 8'h00;
      end else if (ce_i) begin
         shadow <= next_shadow;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || !ce_i);
   sequence s_taken;
      taken;
   endsequence
   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   sequence s_rd_ctrl;
      taken && !wb_we_i && wb_adr_i == 8'h00;
   endsequence
   chk_ack_pulse: assert property (s_taken |=> s_ack_pulse)
      else $error("ack is not one cycle after a request");
   chk_unused_read: assert property (s_rd_ctrl |=> wb_dat_o[6] == 1'b0
      && wb_dat_o[2:1] == 2'h0 && wb_dat_o[7] == shadow[7])
      else $error("unused bits or run bit read wrong");
   chk_rmw_flag: assert property (s_rd_ctrl and rmw_i |=> wb_dat_o[3])
      else $error("flag not read as one in rmw read");
   chk_run_copy: assert property (count_run_o == shadow[7])
      else $error("run output differs from written bit");
   chk_pin_select: assert property (pulse_pin_select_o |-> !pin_oe_n_o)
      else $error("pin not driven in pulse function");
   chk_pin_low: assert property (!count_run_o |-> !(pin_o && pulse_pin_select_o))
      else $error("pulse pin high while counting stopped");
   chk_port_pass: assert property (!pulse_pin_select_o && !$past(rst_i)
      |-> pin_o == $past(port_data_i))
      else $error("port level not passed to pin");
   chk_irq_mask: assert property (!shadow[4] |-> !underflow_irq_o)
      else $error("interrupt raised while disabled");
   chk_uf_sets: assert property (uf_ev && next_en |=> underflow_irq_o)
      else $error("underflow did not raise interrupt");
   chk_clear_flag: assert property (wr_ctrl && !wb_dat_i[3] && !uf_ev
      |=> !underflow_irq_o)
      else $error("zero write did not clear flag");
   chk_flag_sticky: assert property (underflow_irq_o && !wr_ctrl
      |=> $stable(underflow_irq_o))
      else $error("flag changed without a write");
   chk_no_false_uf: assert property (!underflow_irq_o && !wr_ctrl && !uf_ev
      |=> !underflow_irq_o)
      else $error("flag set without underflow");
endmodule

bind pulse_timer_ch0_mode_control pulse_timer_ch0_mode_control_checker chk (.*);

// [test/pulse_timer_ch0_mode_control_tb.sv]
// Purpose: Register and pin tests of the channel 0 mode control block.
// Assumes: ce_i tied high; ticks ride on reads of an unmapped word or on writes to the mode register.
// Notes:   Expected words use bits 31:8 and unused bits as zero.
`timescale 1ns/1ps
module pulse_timer_ch0_mode_control_tb;
   logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, rmw_i = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00, counter0_value_i = 8'h00;
   logic [7:0] counter1_value_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdata;
   logic count_tick_i = 1'b0, mode_select_high_i = 1'b0;
   logic mode_select_low_i = 1'b0, pulse_level_i = 1'b0;
   logic port_data_i = 1'b0, port_dir_i = 1'b0;
   logic wb_ack_o, count_run_o, pulse_pin_select_o, pin_o, pin_oe_n_o;
   logic underflow_irq_o, irq_o;
   int   failures = 0, checked = 0, m;
   always #25 clk_i = ~clk_i;
   pulse_timer_ch0_mode_control DUT (.*);
   task automatic wrap_up;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic we, input logic [7:0] adr,
                       input logic [31:0] dat, input logic rmw,
                       input logic tk);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= 4'h1;
      rmw_i <= rmw;
      count_tick_i <= tk;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_i);
         count_tick_i <= 1'b0;
         if (wb_ack_o === 1'b1) break;
      end
      if (n == 20) begin
         failures++;
         wrap_up();
      end
      rdata = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] adr, input logic rmw,
                     input logic [31:0] exp);
      xfer(1'b0, adr, 32'h0, rmw, 1'b0);
      cmp(rdata, exp);
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(8'h00, 1'b0, 32'h0);
      cmp(pin_oe_n_o, 1'b1);
      $display("test reset done");
      pulse_level_i <= 1'b1;
      xfer(1'b1, 8'h00, 32'hffff_fff7, 1'b0, 1'b0);
      rd(8'h00, 1'b0, 32'hb1);
      cmp({count_run_o, pulse_pin_select_o, pin_o, pin_oe_n_o}, 4'he);
      $display("test fields done");
      for (m = 0; m < 4; m++) begin
         if (m == 2) continue;
         {mode_select_high_i, mode_select_low_i} <= m[1:0];
         counter1_value_i <= 8'h05;
         xfer(1'b0, 8'h10, 32'h0, 1'b0, 1'b1);
         cmp(rdata, 32'h0);
         rd(8'h00, 1'b0, (m == 3) ? 32'hb1 : 32'hb9);
         counter1_value_i <= 8'h00;
         xfer(1'b0, 8'h10, 32'h0, 1'b0, 1'b1);
         rd(8'h00, 1'b0, 32'hb9);
         cmp(underflow_irq_o, 1'b1);
         xfer(1'b1, 8'h00, 32'hb9, 1'b0, 1'b0);
         rd(8'h00, 1'b0, 32'hb9);
         xfer(1'b1, 8'h00, 32'hb1, 1'b0, 1'b0);
         rd(8'h00, 1'b0, 32'hb1);
      end
      $display("test modes done");
      xfer(1'b1, 8'h0c, 32'h3, 1'b0, 1'b0);
      rd(8'h0c, 1'b0, 32'h3);
      rd(8'h04, 1'b0, 32'h1);
      cmp(irq_o, 1'b1);
      xfer(1'b1, 8'h08, 32'h1, 1'b0, 1'b0);
      rd(8'h04, 1'b0, 32'h0);
      cmp(irq_o, 1'b0);
      {mode_select_high_i, mode_select_low_i} <= 2'h2;
      rd(8'h04, 1'b0, 32'h2);
      xfer(1'b1, 8'h08, 32'h2, 1'b0, 1'b0);
      {mode_select_high_i, mode_select_low_i} <= 2'h0;
      xfer(1'b1, 8'h10, 32'hffff_ffff, 1'b0, 1'b0);
      rd(8'h10, 1'b0, 32'h0);
      $display("test events done");
      rd(8'h00, 1'b1, 32'hb9);
      xfer(1'b1, 8'h00, 32'hb1, 1'b0, 1'b1);
      rd(8'h00, 1'b0, 32'hb9);
      xfer(1'b1, 8'h00, 32'ha1, 1'b0, 1'b1);
      rd(8'h00, 1'b0, 32'ha9);
      cmp(underflow_irq_o, 1'b0);
      $display("test flag done");
      xfer(1'b1, 8'h00, 32'h21, 1'b0, 1'b0);
      xfer(1'b0, 8'h10, 32'h0, 1'b0, 1'b1);
      rd(8'h00, 1'b0, 32'h21);
      cmp({count_run_o, pin_o}, 2'h0);
      port_data_i <= 1'b1;
      xfer(1'b1, 8'h00, 32'h01, 1'b0, 1'b0);
      rd(8'h00, 1'b0, 32'h01);
      cmp({pin_o, pin_oe_n_o}, 2'h3);
      // Port function hands the drive decision to the port direction
      port_dir_i <= 1'b1;
      xfer(1'b1, 8'h00, 32'h01, 1'b0, 1'b0);
      cmp({pin_o, pin_oe_n_o}, 2'h2);
      $display("test pin done");
      wrap_up();
   end
endmodule
